/* File: bench/tbtc_tape_model.sv */
// Purpose: cassette playback as seen at the tape input pin
// Assumes: conditioning squares playback, high = tone present
// Notes: a lead tone lets a read start inside tone
`timescale 1ns/100ps
module tbtc_tape_model (
	// system
	input wire logic clk_sys,
	input wire logic rst,
	// control
	input wire logic go,
	input wire logic [7:0] byteVal,
	input wire logic [15:0] thirdLen,
	// pin
	output logic serial_in_pin
);
	int idx;
	int cnt;
	int k;
	logic [8:0] bits;
	// ============================================================
	// thirds: lead tone, gap, then nine bits of three thirds
	always @(posedge clk_sys) begin
		if (rst || go) begin
			idx <= rst ? 29 : 0;
			cnt <= 0;
			bits <= {1'b0, byteVal};
		end else if (idx < 29) begin
			cnt <= (cnt == thirdLen - 1) ? 0 : cnt + 1;
			idx <= (cnt == thirdLen - 1) ? idx + 1 : idx;
		end
	end
	// ============================================================
	// squared level: tone, data third, pause; trailing zero closes the last pause
	always_comb begin
		serial_in_pin = (idx == 0);
		k = (idx - 2) % 3;
		if (idx >= 2 && idx < 29) begin
			serial_in_pin = (k == 0) || (k == 1 && bits[(idx - 2) / 3]);
		end
	end
endmodule

/* File: bench/tone_burst_tape_codec_bench.sv */
// Purpose: self-checking bench of the tape codec
// Assumes: half period 0, four toggles, sample interval 4 after the table
// Notes: tape speed is varied between the two reads
`timescale 1ns/100ps
module tone_burst_tape_codec_bench;
	import tbtc_pkg::*;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} tbtc_row_type;
	logic clk_sys, rst, awV, awR, wV, wR, bV, bRdy, arV, arR, rV, rRdy, sIn, sOut, tGo, txOn, prevPin;
	logic [7:0] awA, arA, tByte, dat;
	logic [31:0] wD, rD, rd, em;
	logic [31:0] txMask = 32'h0000_0000;
	logic [1:0] bResp, rResp, rsp;
	logic [15:0] tLen;
	int bad_count, cmp_count, cyc, t0, tBv, rises, n;
	int tt = 4 * 29;
	tbtc_row_type rows[14] = '{
		'{0, 8'h10, 0, 32'h14, 2'b00}, '{0, 8'h14, 0, 32'h08, 2'b00},
		'{0, 8'h18, 0, 32'h14, 2'b00}, '{0, 8'h08, 0, 0, 2'b00},
		'{0, 8'h1C, 0, 0, 2'b10}, '{1, 8'h1C, 32'h5, 0, 2'b10},
		'{1, 8'h10, 32'hFFFF_FF00, 0, 2'b00}, '{0, 8'h10, 0, 0, 2'b00},
		'{1, 8'h18, 32'h0001_0004, 0, 2'b00}, '{0, 8'h18, 0, 32'h4, 2'b00},
		'{1, 8'h14, 32'h0000_0004, 0, 2'b00}, '{0, 8'h14, 0, 32'h4, 2'b00},
		'{1, 8'h08, 32'h7, 0, 2'b00}, '{0, 8'h08, 0, 0, 2'b00}};
	logic [7:0] rxByte[2] = '{8'h4D, 8'hB4};
	logic [15:0] rxLen[2] = '{16'h00C8, 16'h0096};
	tbtc_codec u_tbtc_codec (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awA),
		.s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bResp), .s_axi_bvalid(bV),
		.s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
		.s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rRdy),
		.serial_in_pin(sIn), .serial_out_pin(sOut));
	tbtc_tape_model u_tbtc_tape_model (.clk_sys(clk_sys), .rst(rst), .go(tGo),
		.byteVal(tByte), .thirdLen(tLen), .serial_in_pin(sIn));
	// ============================================================
	// clock, cycle count and tone monitor
	initial begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		prevPin <= sOut;
		if (txOn && sOut && !prevPin) begin
			rises <= rises + 1;
			if ((cyc - t0) / tt < 32) txMask[(cyc - t0) / tt] <= 1'b1;
		end
	end
	// ============================================================
	// report
	task close_out();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	// ============================================================
	// axi4-lite master; ready and answer sampled before the edge that takes them
	task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		int k;
		awA <= a;
		wD <= d;
		awV <= 1;
		wV <= 1;
		bRdy <= 1;
		tb = 0;
		for (k = 0; k < 200 && !tb; k++) begin
			@(negedge clk_sys);
			ta = awV && awR;
			tw = wV && wR;
			tb = bRdy && bV;
			r = bResp;
			@(posedge clk_sys);
			if (ta) awV <= 0;
			if (tw) wV <= 0;
			if (tb) bRdy <= 0;
			if (tb) tBv = cyc;
		end
		// one idle edge so a following call never re-drives bready in the same step
		@(posedge clk_sys);
		check(tb, "write hang");
		if (tb !== 1'b1) close_out();
	endtask
	task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, got;
		int k;
		arA <= a;
		arV <= 1;
		rRdy <= 1;
		got = 0;
		for (k = 0; k < 200 && !got; k++) begin
			@(negedge clk_sys);
			ta = arV && arR;
			got = rRdy && rV;
			d = rD;
			r = rResp;
			@(posedge clk_sys);
			if (ta) arV <= 0;
			if (got) rRdy <= 0;
		end
		@(posedge clk_sys);
		check(got, "read hang");
		if (got !== 1'b1) close_out();
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		check(0, "run hang");
		close_out();
	end
	// ============================================================
	// main sequence
	initial begin
		{awV, wV, bRdy, arV, rRdy, tGo, txOn} = 0;
		{awA, arA, tByte, wD, tLen} = 0;
		rst = 1;
		repeat (12) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		foreach (rows[i]) begin
			if (rows[i].wr) axi_write(rows[i].a, rows[i].d, rsp);
			else axi_read(rows[i].a, rd, rsp);
			check(rsp === rows[i].r && (rows[i].wr || rd === rows[i].e), "register row");
		end
		dat = 8'hB2;
		txOn <= 1;
		axi_write(8'h00, {24'h0, dat}, rsp);
		t0 = tBv;
		repeat (27 * tt - 20) @(posedge clk_sys);
		axi_read(8'h08, rd, rsp);
		check(rd[0] === 1'b1, "tx ended early");
		repeat (40) @(posedge clk_sys);
		axi_read(8'h08, rd, rsp);
		check(rd[0] === 1'b0, "tx still busy");
		em = 0;
		for (int b = 0; b < 9; b++) begin
			em[3 * b] = 1'b1;
			em[3 * b + 1] = (b < 8) ? dat[b] : 1'b0;
		end
		check(txMask === em, "tone thirds");
		check(rises === 2 * (9 + $countones(dat)), "toggle count");
		for (int i = 0; i < 2; i++) begin
			tByte <= rxByte[i];
			tLen <= rxLen[i];
			tGo <= 1;
			@(posedge clk_sys);
			tGo <= 0;
			repeat (100) @(posedge clk_sys);
			axi_write(8'h04, 32'h1, rsp);
			rd = 0;
			for (n = 0; n < 3000 && rd[2] !== 1'b1; n++) axi_read(8'h08, rd, rsp);
			check(n < 3000, "no byte");
			if (n == 3000) close_out();
			axi_read(8'h0C, rd, rsp);
			check(rd === {24'h0, rxByte[i]}, "rx byte");
			axi_read(8'h08, rd, rsp);
			check(rd[2:1] === 2'b00, "rx idle");
		end
		// ============================================================
		// reset in mid-byte while the pin is high
		axi_write(8'h00, 32'h0000_00FF, rsp);
		repeat (100) @(posedge clk_sys);
		rst <= 1;
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		check(sOut === 1'b0, "pin after reset");
		axi_read(8'h08, rd, rsp);
		check(rd === 32'h0000_0000, "status after reset");
		axi_read(8'h10, rd, rsp);
		check(rd === 32'h0000_0014, "half period after reset");
		close_out();
	end
endmodule

/* File: design/tbtc_cfg.svh */
// Purpose: offsets, field positions, reset values and timing counts of the tape codec
// Assumes: one machine cycle of the tone timing is one clk_sys cycle (8 ns)
// Notes: definitions only
`ifndef TBTC_CFG_SVH
`define TBTC_CFG_SVH

// ============================================================
// register byte offsets
`define TBTC_OFS_TXDATA 8'h00
`define TBTC_OFS_RXCTRL 8'h04
`define TBTC_OFS_STATUS 8'h08
`define TBTC_OFS_RXDATA 8'h0C
`define TBTC_OFS_HALFPER 8'h10
`define TBTC_OFS_TOGGLES 8'h14
`define TBTC_OFS_SAMPINT 8'h18

// ============================================================
// field positions
`define TBTC_RXCTRL_START 0
`define TBTC_ST_TXBUSY 0
`define TBTC_ST_RXBUSY 1
`define TBTC_ST_RXVALID 2

// ============================================================
// reset values
`define TBTC_RST_HALFPER 8'h14
`define TBTC_RST_TOGGLES 8'h08
`define TBTC_RST_SAMPINT 16'h0014

// ============================================================
// timing: toggle spacing = base + step * half period, in machine cycles
`define TBTC_SPACING_BASE 12'h01D
`define TBTC_SPACING_STEP 12'h00E
`define TBTC_TX_BITS 4'h9
`define TBTC_RX_BITS 3'h7
`define TBTC_RESP_OKAY 2'b00
`define TBTC_RESP_SLVERR 2'b10

`endif

/* File: design/tbtc_codec.sv */
// Purpose: tone burst cassette codec with AXI4-Lite registers
// Assumes: analog conditioning squares the playback signal onto serial_in_pin
// Notes: one write byte and one read byte may run at the same time
`timescale 1ns/100ps
`include "tbtc_cfg.svh"

// Operation
// - each transmitted bit is three equal thirds: tone, data-dependent, silence.
// - a received bit is one when its burst outlasted its pause, else zero.
// - a written byte goes out as eight data bits lsb first and one trailing zero bit.
// - the opening tone of the trailing zero is sent to close the last data bit's pause.
// - a tone third toggles the pin an even programmable count at 29 + 14 * half period cycles.
// - a silence third lasts as long as a tone third with the pin held still.
// - a read that starts during tone first waits for it to end, then for the next tone.
// - during a read, an input level change is taken only after two consecutive matching samples.
// - the signed counter goes down each sample of tone after a burst's first and up each sample of silence.
// - the counter's sign at the end of a bit gives the bit, then the counter is cleared.
// - each bit enters the byte from the top so the first bit ends up in bit 0.
// - a read gathers exactly eight bits and stops; the trailing zero is not kept.
// - the tone that ends a pause starts the next bit's measurement at once.
// - a programmable interval paces the input samples.
module tbtc_codec
	import tbtc_pkg::*;
(
	// system
	input wire logic clk_sys,
	input wire logic rst,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// tape pins
	input wire logic serial_in_pin,
	output logic serial_out_pin
);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	tbtc_samp_if samp ();

	tbtc_input_sampler u_sampler (
		.clk_sys(clk_sys),
		.rst(rst),
		.serial_in_pin(serial_in_pin),
		.samp(samp.sampler)
	);

	// ============================================================
	// bus slave state
	logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
	logic [7:0] awAddr_reg, awAddr_next;
	logic [31:0] wData_reg, wData_next;
	logic [3:0] wStrb_reg, wStrb_next;
	logic bValid_reg, bValid_next;
	logic [1:0] bResp_reg, bResp_next;
	logic rValid_reg, rValid_next;
	logic [1:0] rResp_reg, rResp_next;
	logic [31:0] rData_reg, rData_next;
	logic [7:0] halfPer_reg, halfPer_next;
	logic [7:0] toggles_reg, toggles_next;
	logic [15:0] sampInt_reg, sampInt_next;
	logic doWrite, doRead, txStart, rxStart, rxDataRead;
	logic [31:0] mergedWord;

	function automatic logic [31:0] merge(input logic [31:0] oldv, input logic [31:0] newv,
		input logic [3:0] strb);
		logic [31:0] res;
		res = oldv;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[8*i +: 8] = newv[8*i +: 8];
		return res;
	endfunction

	// ============================================================
	// transmit state
	tbtc_tx_state_type txState_reg, txState_next;
	logic [8:0] txShift_reg, txShift_next;
	logic [3:0] txBitCnt_reg, txBitCnt_next;
	logic [1:0] segIdx_reg, segIdx_next;
	logic [7:0] togLeft_reg, togLeft_next, togCfg_reg, togCfg_next;
	logic [11:0] ivCnt_reg, ivCnt_next, spacing_reg, spacing_next;
	logic pin_reg, pin_next;
	logic txTick, txTone, txToggle;
	logic [11:0] newSpacing;
	logic [7:0] newToggles;

	// ============================================================
	// receive state
	tbtc_rx_state_type rxState_reg, rxState_next;
	logic signed [7:0] rxCount_reg, rxCount_next;
	logic [7:0] rxShift_reg, rxShift_next, rxData_reg, rxData_next;
	logic [2:0] rxBitCnt_reg, rxBitCnt_next;
	logic rxValid_reg, rxValid_next;
	logic [15:0] rxInt_reg, rxInt_next;
	logic rxBitDone, rxBitVal;

	// ============================================================
	// bus slave
	always_comb begin
		awHeld_next = awHeld_reg;
		wHeld_next = wHeld_reg;
		awAddr_next = awAddr_reg;
		wData_next = wData_reg;
		wStrb_next = wStrb_reg;
		bValid_next = bValid_reg;
		bResp_next = bResp_reg;
		rValid_next = rValid_reg;
		rResp_next = rResp_reg;
		rData_next = rData_reg;
		halfPer_next = halfPer_reg;
		toggles_next = toggles_reg;
		sampInt_next = sampInt_reg;
		txStart = 1'b0;
		rxStart = 1'b0;
		rxDataRead = 1'b0;
		mergedWord = 32'h0000_0000;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_next = 1'b1;
			awAddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_next = 1'b1;
			wData_next = s_axi_wdata;
			wStrb_next = s_axi_wstrb;
		end
		doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
		if (doWrite) begin
			awHeld_next = 1'b0;
			wHeld_next = 1'b0;
			bValid_next = 1'b1;
			bResp_next = `TBTC_RESP_OKAY;
			case ({awAddr_reg[7:2], 2'b00})
			`TBTC_OFS_TXDATA: txStart = wStrb_reg[0] && txState_reg == TX_IDLE;
			`TBTC_OFS_RXCTRL: rxStart = wStrb_reg[0] && wData_reg[`TBTC_RXCTRL_START]
				&& rxState_reg == RX_IDLE;
			`TBTC_OFS_HALFPER: begin
				mergedWord = merge({24'h00_0000, halfPer_reg}, wData_reg, wStrb_reg);
				halfPer_next = mergedWord[7:0];
			end
			`TBTC_OFS_TOGGLES: begin
				mergedWord = merge({24'h00_0000, toggles_reg}, wData_reg, wStrb_reg);
				toggles_next = mergedWord[7:0];
			end
			`TBTC_OFS_SAMPINT: begin
				mergedWord = merge({16'h0000, sampInt_reg}, wData_reg, wStrb_reg);
				sampInt_next = mergedWord[15:0];
			end
			`TBTC_OFS_STATUS, `TBTC_OFS_RXDATA: bResp_next = `TBTC_RESP_OKAY;
			default: bResp_next = `TBTC_RESP_SLVERR;
			endcase
		end else if (bValid_reg && s_axi_bready) begin
			bValid_next = 1'b0;
		end
		doRead = s_axi_arvalid && s_axi_arready;
		if (doRead) begin
			rValid_next = 1'b1;
			rResp_next = `TBTC_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
			`TBTC_OFS_STATUS: rData_next = {29'h0000_0000, rxValid_reg,
				rxState_reg != RX_IDLE, txState_reg != TX_IDLE};
			`TBTC_OFS_RXDATA: begin
				rData_next = {24'h00_0000, rxData_reg};
				rxDataRead = 1'b1;
			end
			`TBTC_OFS_HALFPER: rData_next = {24'h00_0000, halfPer_reg};
			`TBTC_OFS_TOGGLES: rData_next = {24'h00_0000, toggles_reg};
			`TBTC_OFS_SAMPINT: rData_next = {16'h0000, sampInt_reg};
			`TBTC_OFS_TXDATA, `TBTC_OFS_RXCTRL: rData_next = 32'h0000_0000;
			default: begin
				rData_next = 32'h0000_0000;
				rResp_next = `TBTC_RESP_SLVERR;
			end
			endcase
		end else if (rValid_reg && s_axi_rready) begin
			rValid_next = 1'b0;
		end
	end

	assign s_axi_awready = !awHeld_reg && !bValid_reg;
	assign s_axi_wready = !wHeld_reg && !bValid_reg;
	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp = bResp_reg;
	assign s_axi_arready = !rValid_reg;
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rresp = rResp_reg;
	assign s_axi_rdata = rData_reg;

	// ============================================================
	// transmitter
	always_comb begin
		txState_next = txState_reg;
		txShift_next = txShift_reg;
		txBitCnt_next = txBitCnt_reg;
		segIdx_next = segIdx_reg;
		togLeft_next = togLeft_reg;
		togCfg_next = togCfg_reg;
		ivCnt_next = ivCnt_reg;
		spacing_next = spacing_reg;
		pin_next = pin_reg;
		// odd counts would leave the pin high through a silence, so force even
		newToggles = (toggles_reg[7:1] == 7'h00) ? 8'h02 : {toggles_reg[7:1], 1'b0};
		newSpacing = `TBTC_SPACING_BASE + `TBTC_SPACING_STEP * {4'h0, halfPer_reg};
		txTick = txState_reg == TX_RUN && ivCnt_reg == 12'h000;
		txTone = segIdx_reg == 2'd0 || (segIdx_reg == 2'd1 && txShift_reg[0]);
		txToggle = txTick && txTone;
		case (txState_reg)
		TX_IDLE: begin
			if (txStart) begin
				txState_next = TX_RUN;
				txShift_next = {1'b0, wData_reg[7:0]};
				txBitCnt_next = 4'h0;
				segIdx_next = 2'd0;
				togCfg_next = newToggles;
				togLeft_next = newToggles;
				spacing_next = newSpacing;
				ivCnt_next = newSpacing - 12'h001;
				pin_next = 1'b0;
			end
		end
		TX_RUN: begin
			if (txTick) begin
				ivCnt_next = spacing_reg - 12'h001;
				if (txToggle)
					pin_next = !pin_reg;
				// silence counts the same intervals without touching the pin
				if (togLeft_reg == 8'h01) begin
					togLeft_next = togCfg_reg;
					if (segIdx_reg == 2'd2) begin
						segIdx_next = 2'd0;
						txShift_next = {1'b0, txShift_reg[8:1]};
						txBitCnt_next = txBitCnt_reg + 4'h1;
						// the trailing zero's full tone bounds the last data pause
						if (txBitCnt_reg == `TBTC_TX_BITS - 4'h1)
							txState_next = TX_IDLE;
					end else begin
						segIdx_next = segIdx_reg + 2'd1;
					end
				end else begin
					togLeft_next = togLeft_reg - 8'h01;
				end
			end else begin
				ivCnt_next = ivCnt_reg - 12'h001;
			end
		end
		default: txState_next = TX_IDLE;
		endcase
	end

	assign serial_out_pin = pin_reg;

	// ============================================================
	// receiver
	always_comb begin
		rxState_next = rxState_reg;
		rxCount_next = rxCount_reg;
		rxShift_next = rxShift_reg;
		rxBitCnt_next = rxBitCnt_reg;
		rxData_next = rxData_reg;
		rxInt_next = rxInt_reg;
		rxBitDone = 1'b0;
		// ratio only, so tape speed drift cancels out
		rxBitVal = rxCount_reg[7];
		rxValid_next = rxValid_reg && !rxDataRead;
		case (rxState_reg)
		RX_IDLE: begin
			if (rxStart) begin
				rxState_next = RX_WAITEND;
				rxInt_next = sampInt_reg;
				rxCount_next = 8'sh00;
				rxBitCnt_next = 3'h0;
			end
		end
		RX_WAITEND: begin
			if (samp.tick && !samp.level)
				rxState_next = RX_WAITTONE;
		end
		RX_WAITTONE: begin
			if (samp.tick && samp.level) begin
				rxState_next = RX_BURST;
				rxCount_next = 8'sh00;
			end
		end
		RX_BURST: begin
			if (samp.tick) begin
				// wraps if the interval is too fine for the tone length
				if (samp.level) begin
					rxCount_next = rxCount_reg - 8'sh01;
				end else begin
					rxState_next = RX_PAUSE;
					rxCount_next = rxCount_reg + 8'sh01;
				end
			end
		end
		RX_PAUSE: begin
			if (samp.tick) begin
				if (!samp.level) begin
					rxCount_next = rxCount_reg + 8'sh01;
				end else begin
					rxBitDone = 1'b1;
					rxCount_next = 8'sh00;
					rxShift_next = {rxBitVal, rxShift_reg[7:1]};
					rxBitCnt_next = rxBitCnt_reg + 3'h1;
					if (rxBitCnt_reg == `TBTC_RX_BITS) begin
						rxState_next = RX_IDLE;
						rxData_next = {rxBitVal, rxShift_reg[7:1]};
					end else begin
						rxState_next = RX_BURST;
					end
				end
			end
		end
		default: rxState_next = RX_IDLE;
		endcase
		if (rxBitDone && rxBitCnt_reg == `TBTC_RX_BITS)
			rxValid_next = 1'b1;
	end

	assign samp.run = rxState_reg != RX_IDLE;
	assign samp.interval = rxInt_reg;

	// ============================================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			bValid_reg <= 1'b0;
			bResp_reg <= `TBTC_RESP_OKAY;
			rValid_reg <= 1'b0;
			rResp_reg <= `TBTC_RESP_OKAY;
			rData_reg <= 32'h0000_0000;
			halfPer_reg <= `TBTC_RST_HALFPER;
			toggles_reg <= `TBTC_RST_TOGGLES;
			sampInt_reg <= `TBTC_RST_SAMPINT;
			txState_reg <= TX_IDLE;
			txShift_reg <= 9'h000;
			txBitCnt_reg <= 4'h0;
			segIdx_reg <= 2'd0;
			togLeft_reg <= 8'h00;
			togCfg_reg <= 8'h00;
			ivCnt_reg <= 12'h000;
			spacing_reg <= 12'h000;
			pin_reg <= 1'b0;
			rxState_reg <= RX_IDLE;
			rxCount_reg <= 8'sh00;
			rxShift_reg <= 8'h00;
			rxData_reg <= 8'h00;
			rxBitCnt_reg <= 3'h0;
			rxValid_reg <= 1'b0;
			rxInt_reg <= `TBTC_RST_SAMPINT;
		end else begin
			awHeld_reg <= awHeld_next;
			wHeld_reg <= wHeld_next;
			awAddr_reg <= awAddr_next;
			wData_reg <= wData_next;
			wStrb_reg <= wStrb_next;
			bValid_reg <= bValid_next;
			bResp_reg <= bResp_next;
			rValid_reg <= rValid_next;
			rResp_reg <= rResp_next;
			rData_reg <= rData_next;
			halfPer_reg <= halfPer_next;
			toggles_reg <= toggles_next;
			sampInt_reg <= sampInt_next;
			txState_reg <= txState_next;
			txShift_reg <= txShift_next;
			txBitCnt_reg <= txBitCnt_next;
			segIdx_reg <= segIdx_next;
			togLeft_reg <= togLeft_next;
			togCfg_reg <= togCfg_next;
			ivCnt_reg <= ivCnt_next;
			spacing_reg <= spacing_next;
			pin_reg <= pin_next;
			rxState_reg <= rxState_next;
			rxCount_reg <= rxCount_next;
			rxShift_reg <= rxShift_next;
			rxData_reg <= rxData_next;
			rxBitCnt_reg <= rxBitCnt_next;
			rxValid_reg <= rxValid_next;
			rxInt_reg <= rxInt_next;
		end
	end

	// ============================================================
	// checks
	pin_moves_tone_a: assert property (
		$changed(serial_out_pin) |-> $past(txToggle) && $past(segIdx_reg) != 2'd2)
		else $error("pin moved outside a tone third");
	toggle_spacing_a: assert property (
		txTick && txState_next == TX_RUN |=> ivCnt_reg == spacing_reg - 12'h001)
		else $error("toggle interval reload wrong");
	nine_bits_a: assert property (
		txTick && togLeft_reg == 8'h01 && segIdx_reg == 2'd2 && txBitCnt_reg == 4'h8
		|=> txState_reg == TX_IDLE)
		else $error("transmitter did not stop after nine bits");
	silence_low_a: assert property (
		txState_reg == TX_RUN && segIdx_reg == 2'd2 |-> !serial_out_pin)
		else $error("pin not low in closing silence");
	burst_count_a: assert property (
		rxState_reg == RX_BURST && samp.tick && samp.level
		|=> rxCount_reg == $past(rxCount_reg) - 8'sh01)
		else $error("burst sample not counted down");
	bit_sign_a: assert property (
		rxBitDone |=> rxShift_reg[7] == $past(rxCount_reg[7]) && rxCount_reg == 8'sh00)
		else $error("bit not taken from counter sign");
	byte_done_a: assert property (
		rxBitDone && rxBitCnt_reg == 3'h7 |=> rxState_reg == RX_IDLE && rxValid_reg)
		else $error("read did not finish after eight bits");
	next_bit_a: assert property (
		rxBitDone && rxBitCnt_reg != 3'h7 |=> rxState_reg == RX_BURST)
		else $error("ending tone not reused as next burst");
	wait_tone_end_a: assert property (
		rxState_reg == RX_WAITEND && !(samp.tick && !samp.level) |=> rxState_reg == RX_WAITEND)
		else $error("left wait before tone ended");

endmodule

/* File: design/tbtc_input_sampler.sv */
// Purpose: paced, filtered sampling of the tape input pin
// Assumes: serial_in_pin is asynchronous to clk_sys
// Notes: level follows the pin while idle so a read starts from the present state
`timescale 1ns/100ps
module tbtc_input_sampler
	import tbtc_pkg::*;
(
	// system
	input wire logic clk_sys,
	input wire logic rst,
	// pin
	input wire logic serial_in_pin,
	// core side
	tbtc_samp_if.sampler samp
);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	logic syncA_reg, syncB_reg;
	logic [15:0] divCnt_reg, divCnt_next;
	logic lastSample_reg, lastSample_next;
	logic level_reg, level_next;
	logic tick_reg, tick_next;
	logic sampleNow;
	logic [15:0] lastCount;

	// ============================================================
	// pacing and two-sample filter
	always_comb begin
		lastCount = (samp.interval == 16'h0000) ? 16'h0000 : samp.interval - 16'h0001;
		sampleNow = samp.run && (divCnt_reg == lastCount);
		divCnt_next = sampleNow ? 16'h0000 : divCnt_reg + 16'h0001;
		lastSample_next = lastSample_reg;
		level_next = level_reg;
		tick_next = sampleNow;
		if (!samp.run) begin
			divCnt_next = 16'h0000;
			lastSample_next = syncB_reg;
			level_next = syncB_reg;
		end else if (sampleNow) begin
			lastSample_next = syncB_reg;
			if (syncB_reg == lastSample_reg)
				level_next = syncB_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		syncA_reg <= serial_in_pin;
		syncB_reg <= syncA_reg;
		if (rst) begin
			divCnt_reg <= 16'h0000;
			lastSample_reg <= 1'b0;
			level_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			divCnt_reg <= divCnt_next;
			lastSample_reg <= lastSample_next;
			level_reg <= level_next;
			tick_reg <= tick_next;
		end
	end

	assign samp.tick = tick_reg;
	assign samp.level = level_reg;

	// ============================================================
	// checks
	level_two_samples_a: assert property (
		samp.run && $past(samp.run) && $changed(level_reg)
		|-> $past(tick_next) && $past(lastSample_reg) == level_reg)
		else $error("level changed without two matching samples");
	tick_pacing_a: assert property (
		tick_reg && samp.interval == 16'h0004 && samp.run
		|-> ##1 !tick_reg ##1 !tick_reg ##1 !tick_reg)
		else $error("sample ticks closer than the interval");

endmodule

/* File: design/tbtc_pkg.sv */
// Purpose: types shared by the tape codec modules
// Assumes: nothing
// Notes: gray codes along the usual path
package tbtc_pkg;

	// ============================================================
	// state types
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_RUN = 2'b01
	} tbtc_tx_state_type;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_WAITEND = 3'b001,
		RX_WAITTONE = 3'b011,
		RX_BURST = 3'b010,
		RX_PAUSE = 3'b110
	} tbtc_rx_state_type;

endpackage

/* File: design/tbtc_samp_if.sv */
// Purpose: link between the codec core and its input sampler
// Assumes: one clock domain
// Notes: tick and level arrive together
`timescale 1ns/100ps
interface tbtc_samp_if;
	logic run;
	logic [15:0] interval;
	logic tick;
	logic level;

	modport core (output run, output interval, input tick, input level);
	modport sampler (input run, input interval, output tick, output level);
endinterface
